// >>> bst_pkg.sv
// Shared constants and types of the backscatter identification transmitter.
// Assumes one 200 MHz system clock and a synchronous active-high reset.
package bst_pkg;

    // Clock and bit rates
    localparam int SYS_CLK_HZ = 200_000_000;
    localparam int BIT_RATE_SLOW_BPS = 64_000;
    localparam int BIT_RATE_FAST_BPS = 256_000;
    localparam int QTR_PER_BIT = 4;
    localparam int DIV_W = 10;
    localparam logic [DIV_W-1:0] QTR_RELOAD_SLOW = DIV_W'(SYS_CLK_HZ / (QTR_PER_BIT * BIT_RATE_SLOW_BPS) - 1);
    localparam logic [DIV_W-1:0] QTR_RELOAD_FAST = DIV_W'(SYS_CLK_HZ / (QTR_PER_BIT * BIT_RATE_FAST_BPS) - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = 10'h000;
    localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;

    // Quarter positions within a bit period
    localparam logic [1:0] QTR_ONE = 2'h0;
    localparam logic [1:0] QTR_ZERO = 2'h2;
    localparam logic [1:0] QTR_LAST = 2'h3;
    localparam logic [1:0] QTR_INC = 2'h1;

    // Frame layout: 8 zeros, 2 low periods, one, then 64 ID bits
    localparam logic [6:0] BIT_FIRST = 7'h00;
    localparam logic [6:0] BIT_INC = 7'h01;
    localparam logic [6:0] SYNC_LOW_FIRST = 7'h08;
    localparam logic [6:0] SYNC_ONE_IDX = 7'h0A;
    localparam logic [6:0] FRAME_LAST_IDX = 7'h4A;

    // ID field positions
    localparam int EXT_MSB = 63;
    localparam int MAKER_MSB = 61;
    localparam int MAKER_LSB = 54;
    localparam int SERIAL_MSB = 53;
    localparam int SERIAL_LSB = 16;
    localparam int CHK_MSB = 15;
    localparam int CHK_LSB = 0;
    localparam logic [1:0] EXT_VALUE = 2'h0;

    // Control field: bit 4 selects the fast rate, bits 1:0 the delay width
    localparam int CTRL_RATE_BIT = 4;
    localparam int CTRL_WSEL_MSB = 1;
    localparam int CTRL_WSEL_LSB = 0;
    localparam logic CFG_FAST_RST = 1'b0;
    localparam logic [1:0] CFG_WSEL_RST = 2'h3;

    // Delay comparison masks
    localparam logic [15:0] DLY_MASK_1K = 16'h03FF;
    localparam logic [15:0] DLY_MASK_4K = 16'h0FFF;
    localparam logic [15:0] DLY_MASK_16K = 16'h3FFF;
    localparam logic [15:0] DLY_MASK_64K = 16'hFFFF;
    localparam int INIT_SHIFT = 3;
    localparam logic [2:0] INIT_TX_COUNT = 3'h4;
    localparam logic [2:0] TXN_INC = 3'h1;
    localparam logic [15:0] DLY_ZERO = 16'h0000;
    localparam logic [15:0] DLY_INC = 16'h0001;

    // Pseudo-random generator: x^16 + x^14 + x^13 + x^11 + 1
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [15:0] LFSR_RST = 16'h0001;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_WAIT = 3'b010,
        ST_SEND = 3'b100
    } bst_state_t;

endpackage : bst_pkg

// >>> bst_rng_if.sv
// Link between the transmitter sequencer and its pseudo-random generator.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface bst_rng_if;
    logic seed_load;
    logic step;
    logic [15:0] seed;
    logic [15:0] value;
    modport gen (input seed_load, input step, input seed, output value);
    modport user (output seed_load, output step, output seed, input value);
endinterface : bst_rng_if
`default_nettype wire

// >>> bst_prng.sv
// 16-bit maximal-length pseudo-random generator with seed load.
// Assumes the sequencer pulses seed_load once after reset, then step per message.
`timescale 1ns/1ps
`default_nettype none
module bst_prng
    import bst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    bst_rng_if.gen rng
);

    logic [15:0] lfsr_ff;
    logic [15:0] nxt_lfsr;

    always_comb begin
        nxt_lfsr = lfsr_ff;
        if (rng.seed_load) begin
            // A zero seed would lock the register, so it is replaced
            nxt_lfsr = (rng.seed == DLY_ZERO) ? LFSR_RST : rng.seed;
        end else if (rng.step) begin
            nxt_lfsr = {1'b0, lfsr_ff[15:1]} ^ (lfsr_ff[0] ? LFSR_TAPS : DLY_ZERO);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lfsr_ff <= LFSR_RST;
        end else begin
            lfsr_ff <= nxt_lfsr;
        end
    end

    assign rng.value = lfsr_ff;

    ////////////////////////////////////////////////////////////////////////////
    property p_prng_nonzero;
        @(posedge sys_clk) disable iff (rst) lfsr_ff != DLY_ZERO;
    endproperty
    a_prng_nonzero: assert property (p_prng_nonzero) else $error("generator reached zero");

    property p_prng_moves;
        @(posedge sys_clk) disable iff (rst) (rng.step && !rng.seed_load) |=> lfsr_ff != $past(lfsr_ff);
    endproperty
    a_prng_moves: assert property (p_prng_moves) else $error("generator did not step");

    c_prng_step: cover property (@(posedge sys_clk) disable iff (rst) rng.step);

endmodule : bst_prng
`default_nettype wire

// >>> bst_tx.sv
// Transmit logic of a passive read-only identification tag.
// Assumes the ID and control fields are static factory straps and rst is power-on reset.
`timescale 1ns/1ps
`default_nettype none
module bst_tx
    import bst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [63:0] id_code,
    input wire logic [4:0] control_code,
    output logic antenna_load_switch,
    output logic storage_isolation_switch,
    output logic tx_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Generator link
    bst_rng_if rng ();

    bst_prng u_prng (
        .sys_clk(sys_clk),
        .rst(rst),
        .rng(rng)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    bst_state_t st_ff;
    bst_state_t nxt_st;
    logic [15:0] dly_cnt_ff;
    logic [15:0] nxt_dly_cnt;
    logic [6:0] bit_idx_ff;
    logic [6:0] nxt_bit_idx;
    logic [2:0] txn_ff;
    logic [2:0] nxt_txn;
    logic cfg_fast_ff;
    logic nxt_cfg_fast;
    logic [1:0] cfg_wsel_ff;
    logic [1:0] nxt_cfg_wsel;
    logic tx_active_ff;
    logic nxt_tx_active;
    logic seed_load;
    logic rng_step;

    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic [1:0] qtr_ff;
    logic [1:0] nxt_qtr;
    logic qtick;
    logic bit_tick;

    logic load_ff;
    logic nxt_load;
    logic iso_ff;
    logic nxt_iso;

    logic [15:0] base_mask;
    logic [15:0] eff_mask;
    logic cnt_hit;
    logic [63:0] id_tx;
    logic [6:0] id_pos;
    logic sym_one;
    logic sym_zero;
    logic mod_req;

    ////////////////////////////////////////////////////////////////////////////
    // Quarter-bit divider
    always_comb begin
        qtick = (div_ff == DIV_ZERO);
        bit_tick = qtick && (qtr_ff == QTR_LAST);
        nxt_div = div_ff - DIV_ONE;
        nxt_qtr = qtr_ff;
        if (qtick) begin
            nxt_div = cfg_fast_ff ? QTR_RELOAD_FAST : QTR_RELOAD_SLOW;
            nxt_qtr = qtr_ff + QTR_INC;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_ff <= DIV_ZERO;
            qtr_ff <= QTR_ONE;
        end else begin
            div_ff <= nxt_div;
            qtr_ff <= nxt_qtr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay comparison width
    always_comb begin
        unique case (cfg_wsel_ff)
            2'h0: base_mask = DLY_MASK_1K;
            2'h1: base_mask = DLY_MASK_4K;
            2'h2: base_mask = DLY_MASK_16K;
            2'h3: base_mask = DLY_MASK_64K;
        endcase
        // Early transmissions wait at most an eighth of the full range
        eff_mask = (txn_ff != INIT_TX_COUNT) ? (base_mask >> INIT_SHIFT) : base_mask;
        cnt_hit = ((dly_cnt_ff & eff_mask) == (rng.value & eff_mask));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_dly_cnt = dly_cnt_ff;
        nxt_bit_idx = bit_idx_ff;
        nxt_txn = txn_ff;
        nxt_cfg_fast = cfg_fast_ff;
        nxt_cfg_wsel = cfg_wsel_ff;
        seed_load = 1'b0;
        rng_step = 1'b0;
        unique case (st_ff)
            ST_BOOT: begin
                seed_load = 1'b1;
                nxt_cfg_fast = control_code[CTRL_RATE_BIT];
                nxt_cfg_wsel = control_code[CTRL_WSEL_MSB:CTRL_WSEL_LSB];
                nxt_dly_cnt = DLY_ZERO;
                nxt_st = ST_WAIT;
            end
            ST_WAIT: begin
                if (bit_tick) begin
                    if (cnt_hit) begin
                        nxt_st = ST_SEND;
                        nxt_bit_idx = BIT_FIRST;
                        nxt_dly_cnt = DLY_ZERO;
                        rng_step = 1'b1;
                        if (txn_ff != INIT_TX_COUNT) begin
                            nxt_txn = txn_ff + TXN_INC;
                        end
                    end else begin
                        nxt_dly_cnt = dly_cnt_ff + DLY_INC;
                    end
                end
            end
            ST_SEND: begin
                if (bit_tick) begin
                    if (bit_idx_ff == FRAME_LAST_IDX) begin
                        nxt_st = ST_WAIT;
                    end else begin
                        nxt_bit_idx = bit_idx_ff + BIT_INC;
                    end
                end
            end
        endcase
        nxt_tx_active = (nxt_st == ST_SEND);
    end

    // Reset holds every register of the block, the switches included
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff <= ST_BOOT;
            dly_cnt_ff <= DLY_ZERO;
            bit_idx_ff <= BIT_FIRST;
            txn_ff <= 3'h0;
            cfg_fast_ff <= CFG_FAST_RST;
            cfg_wsel_ff <= CFG_WSEL_RST;
            tx_active_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            dly_cnt_ff <= nxt_dly_cnt;
            bit_idx_ff <= nxt_bit_idx;
            txn_ff <= nxt_txn;
            cfg_fast_ff <= nxt_cfg_fast;
            cfg_wsel_ff <= nxt_cfg_wsel;
            tx_active_ff <= nxt_tx_active;
        end
    end

    assign rng.seed_load = seed_load;
    assign rng.step = rng_step;
    assign rng.seed = id_code[CHK_MSB:CHK_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Frame symbol and position encoding
    always_comb begin
        // Extension bits forced to 00; checksum goes out as stored
        id_tx = {EXT_VALUE, id_code[MAKER_MSB:MAKER_LSB], id_code[SERIAL_MSB:SERIAL_LSB],
                 id_code[CHK_MSB:CHK_LSB]};
        id_pos = FRAME_LAST_IDX - bit_idx_ff;
        sym_one = 1'b0;
        sym_zero = 1'b0;
        if (bit_idx_ff < SYNC_LOW_FIRST) begin
            sym_zero = 1'b1;
        end else if (bit_idx_ff == SYNC_ONE_IDX) begin
            sym_one = 1'b1;
        end else if (bit_idx_ff > SYNC_ONE_IDX) begin
            sym_one = id_tx[id_pos[5:0]];
            sym_zero = !id_tx[id_pos[5:0]];
        end
        mod_req = (st_ff == ST_SEND) &&
                  ((sym_one && qtr_ff == QTR_ONE) || (sym_zero && qtr_ff == QTR_ZERO));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch drive, break-before-make
    always_comb begin
        nxt_load = mod_req && !iso_ff;
        nxt_iso = !mod_req && !load_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            load_ff <= 1'b0;
            iso_ff <= 1'b1;
        end else begin
            load_ff <= nxt_load;
            iso_ff <= nxt_iso;
        end
    end

    assign antenna_load_switch = load_ff;
    assign storage_isolation_switch = iso_ff;
    assign tx_active = tx_active_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_reset_switches;
        @(posedge sys_clk) rst |=> (!antenna_load_switch && storage_isolation_switch);
    endproperty
    a_reset_switches: assert property (p_reset_switches) else $error("switches wrong in reset");

    property p_never_both;
        @(posedge sys_clk) disable iff (rst) !(antenna_load_switch && storage_isolation_switch);
    endproperty
    a_never_both: assert property (p_never_both) else $error("both switches on");

    property p_make_after_break;
        @(posedge sys_clk) disable iff (rst)
            $rose(antenna_load_switch) |-> !storage_isolation_switch && !$past(storage_isolation_switch);
    endproperty
    a_make_after_break: assert property (p_make_after_break) else $error("load on without break");

    property p_restore_after_release;
        @(posedge sys_clk) disable iff (rst)
            $rose(storage_isolation_switch) |-> !antenna_load_switch && !$past(antenna_load_switch);
    endproperty
    a_restore_after_release: assert property (p_restore_after_release) else $error("isolation on too early");

    property p_load_only_in_frame;
        @(posedge sys_clk) disable iff (rst) antenna_load_switch |-> tx_active;
    endproperty
    a_load_only_in_frame: assert property (p_load_only_in_frame) else $error("load outside frame");

    property p_seed_loaded;
        @(posedge sys_clk) disable iff (rst)
            (st_ff == ST_BOOT && id_code[CHK_MSB:CHK_LSB] != DLY_ZERO) |=> rng.value == $past(id_code[CHK_MSB:CHK_LSB]);
    endproperty
    a_seed_loaded: assert property (p_seed_loaded) else $error("seed not loaded at boot");

    property p_count_step;
        @(posedge sys_clk) disable iff (rst)
            (st_ff == ST_WAIT && bit_tick && !cnt_hit) |=> dly_cnt_ff == $past(dly_cnt_ff) + DLY_INC;
    endproperty
    a_count_step: assert property (p_count_step) else $error("delay count did not advance");

    property p_match_starts_frame;
        @(posedge sys_clk) disable iff (rst)
            (st_ff == ST_WAIT && bit_tick && cnt_hit) |=> tx_active && dly_cnt_ff == DLY_ZERO && bit_idx_ff == BIT_FIRST;
    endproperty
    a_match_starts_frame: assert property (p_match_starts_frame) else $error("match did not start frame");

    property p_delay_in_range;
        @(posedge sys_clk) disable iff (rst) st_ff == ST_WAIT |-> (dly_cnt_ff & ~eff_mask) == DLY_ZERO;
    endproperty
    a_delay_in_range: assert property (p_delay_in_range) else $error("delay beyond range");

    property p_frame_length;
        @(posedge sys_clk) disable iff (rst) $fell(tx_active) |-> $past(bit_idx_ff) == FRAME_LAST_IDX;
    endproperty
    a_frame_length: assert property (p_frame_length) else $error("frame length wrong");

    property p_preamble_zero;
        @(posedge sys_clk) disable iff (rst)
            (st_ff == ST_SEND && bit_idx_ff < SYNC_LOW_FIRST) |-> mod_req == (qtr_ff == QTR_ZERO);
    endproperty
    a_preamble_zero: assert property (p_preamble_zero) else $error("preamble not zeros");

    property p_sync_low;
        @(posedge sys_clk) disable iff (rst)
            (st_ff == ST_SEND && bit_idx_ff >= SYNC_LOW_FIRST && bit_idx_ff < SYNC_ONE_IDX) |-> !mod_req;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("sync not low");

    property p_ext_first;
        @(posedge sys_clk) disable iff (rst)
            (st_ff == ST_SEND && bit_idx_ff > SYNC_ONE_IDX && bit_idx_ff < SYNC_ONE_IDX + 7'h03) |-> !sym_one;
    endproperty
    a_ext_first: assert property (p_ext_first) else $error("extension bits not zero");

    c_frame_start: cover property (@(posedge sys_clk) disable iff (rst) $rose(tx_active));
    c_load_pulse: cover property (@(posedge sys_clk) disable iff (rst) $rose(antenna_load_switch));
    c_full_range: cover property (@(posedge sys_clk) disable iff (rst) $rose(tx_active) && txn_ff == INIT_TX_COUNT);
    c_fast_rate: cover property (@(posedge sys_clk) disable iff (rst) tx_active && cfg_fast_ff);

endmodule : bst_tx
`default_nettype wire

// >>> bst_reader.sv
// Reader-side model: samples the load switch in the middle of every quarter of a frame.
// Assumes tx_active marks the frame and qtr_len gives the quarter length in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module bst_reader (
    input wire logic sys_clk,
    input wire logic antenna_load_switch,
    input wire logic tx_active,
    input wire logic [9:0] qtr_len,
    output logic [299:0] qtr_seen,
    output logic [31:0] active_len
);
    logic act_ff;
    int cyc;

    initial begin
        act_ff = 1'b0;
        cyc = 0;
        qtr_seen = '0;
        active_len = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reflected energy is only seen through the load switch
    always @(posedge sys_clk) begin
        act_ff <= tx_active;
        if (tx_active && !act_ff) begin
            cyc <= 1;
            qtr_seen <= '0;
            active_len <= 32'h0000_0001;
        end else if (tx_active) begin
            cyc <= cyc + 1;
            active_len <= active_len + 32'h0000_0001;
            if ((cyc % int'(qtr_len)) == int'(qtr_len) / 2 && cyc / int'(qtr_len) < 300) begin
                qtr_seen[cyc / int'(qtr_len)] <= antenna_load_switch;
            end
        end
    end
endmodule : bst_reader
`default_nettype wire

// >>> bst_tx_tb.sv
// Self-checking testbench of the backscatter identification transmitter.
// Assumes bst_pkg, bst_rng_if, bst_prng, bst_tx and bst_reader are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bst_tx_tb
    import bst_pkg::*;
;
    localparam int QF = int'(QTR_RELOAD_FAST) + 1;
    localparam int QS = int'(QTR_RELOAD_SLOW) + 1;
    logic sys_clk;
    logic rst;
    logic rst_q;
    logic [63:0] id_code;
    logic [4:0] control_code;
    logic antenna_load_switch;
    logic storage_isolation_switch;
    logic tx_active;
    logic [9:0] qtr_len;
    logic [299:0] qtr_seen;
    logic [31:0] active_len;
    logic ld_q;
    logic iso_q;
    logic [31:0] lat_a;
    logic [31:0] lat_b;
    logic [63:0] id_full;
    int bad_count;
    int n_tests;

    bst_tx dut_u (.sys_clk(sys_clk), .rst(rst), .id_code(id_code), .control_code(control_code),
        .antenna_load_switch(antenna_load_switch), .storage_isolation_switch(storage_isolation_switch),
        .tx_active(tx_active));
    bst_reader rdr_u (.sys_clk(sys_clk), .antenna_load_switch(antenna_load_switch), .tx_active(tx_active),
        .qtr_len(qtr_len), .qtr_seen(qtr_seen), .active_len(active_len));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks and verdict
    task automatic conclude();
        $display("Checks made: %0d, mismatches: %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk_v(input string what, input logic [299:0] exp, input logic [299:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_v

    task automatic chk_n(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_n

    // Quarter pattern of a whole frame, first bit at index 0
    function automatic logic [299:0] exp_frame(input logic [63:0] idv);
        logic [299:0] f;
        logic [74:0] b;
        f = '0;
        b = {8'h00, 2'b00, 1'b1, 2'b00, idv[61:0]};
        for (int i = 0; i < 75; i++) begin
            if (i != 8 && i != 9) begin
                f[i * 4 + (b[74 - i] ? 0 : 2)] = 1'b1;
            end
        end
        return f;
    endfunction : exp_frame

    // Reset with new straps, then count cycles from release to frame start
    task automatic boot(input logic [4:0] ctl, input logic [63:0] idv, output logic [31:0] lat);
        @(posedge sys_clk);
        rst <= 1'b1;
        control_code <= ctl;
        id_code <= idv;
        qtr_len <= ctl[4] ? 10'(QF) : 10'(QS);
        repeat (12) @(posedge sys_clk);
        #1;
        chk_v("reset_outputs", 300'h2, {antenna_load_switch, storage_isolation_switch, tx_active});
        @(posedge sys_clk);
        rst <= 1'b0;
        lat = 32'h0;
        while (tx_active !== 1'b1) begin
            @(posedge sys_clk);
            lat++;
            if (lat > 32'd4000) begin
                chk_n("frame_start_timeout", 32'h0, lat);
                conclude();
            end
        end
    endtask : boot

    ////////////////////////////////////////////////////////////////////////////////
    // Switch order watched on every cycle outside reset
    always @(posedge sys_clk) begin
        rst_q <= rst;
        ld_q <= antenna_load_switch;
        iso_q <= storage_isolation_switch;
        if (!rst && !rst_q) begin
            chk_n("load_with_isolation", 32'h0, {31'h0, antenna_load_switch & storage_isolation_switch});
            chk_n("load_make_early", 32'h0, {31'h0, antenna_load_switch & ~ld_q & iso_q});
            chk_n("iso_make_early", 32'h0, {31'h0, storage_isolation_switch & ~iso_q & ld_q});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        rst = 1'b1;
        rst_q = 1'b1;
        id_code = 64'h0;
        control_code = 5'h00;
        qtr_len = 10'(QF);
        bad_count = 0;
        n_tests = 0;
        // Top bits set to see that they go out as 00; low seven bits clear give a zero first delay
        id_full = 64'hD6A5_C3E1_F0F0_1E80;
        boot(5'h10, id_full, lat_a);
        n = 0;
        while (tx_active === 1'b1 && n < 70000) begin
            @(posedge sys_clk);
            n++;
        end
        // A frame that never ends uses up the bound and counts as a mismatch
        chk_n("frame_end_timeout", 32'h0, {31'h0, tx_active});
        repeat (4) @(posedge sys_clk);
        chk_v("frame_quarters", exp_frame(id_full), qtr_seen);
        chk_n("frame_length", 32'(300 * QF), active_len);
        // Slow rate: first three preamble zeros
        boot(5'h01, 64'h0000_0000_0000_0200, lat_b);
        repeat (12 * QS + 400) @(posedge sys_clk);
        chk_v("slow_preamble", 300'h444, {288'h0, qtr_seen[11:0]});
        // Each delay width: seed just above the shortened mask starts at once
        for (int w = 0; w < 4; w++) begin
            boot({3'b100, 2'(w)}, 64'h1 << (7 + 2 * w), lat_b);
            chk_n("first_delay_width", lat_a, lat_b);
        end
        // Masked value one more means one more bit period of delay
        boot(5'h10, 64'h0000_0000_0000_0081, lat_b);
        chk_n("delay_step", lat_a + 32'(4 * QF), lat_b);
        conclude();
    end
endmodule : bst_tx_tb
`default_nettype wire
